/* File: include/coord_regs_pkg.sv */
// package: offsets, field layouts, reset values and carriers of the cursor/window coordinate bank
package coord_regs_pkg;

    // register indices; the byte address on the bus is four times the index
    localparam logic [5:0] IDX_SPRITE_ORIGIN_X = 6'h04;
    localparam logic [5:0] IDX_SPRITE_ORIGIN_Y = 6'h05;
    localparam logic [5:0] IDX_WINDOW_START_X_LOW = 6'h10;
    localparam logic [5:0] IDX_WINDOW_START_X_HIGH = 6'h11;
    localparam logic [5:0] IDX_WINDOW_STOP_X_LOW = 6'h12;
    localparam logic [5:0] IDX_WINDOW_STOP_X_HIGH = 6'h13;
    localparam logic [5:0] IDX_WINDOW_START_Y_LOW = 6'h14;
    localparam logic [5:0] IDX_WINDOW_START_Y_HIGH = 6'h15;
    localparam logic [5:0] IDX_WINDOW_STOP_Y_LOW = 6'h16;
    localparam logic [5:0] IDX_WINDOW_STOP_Y_HIGH = 6'h17;

    // the eight window bytes form one block starting at the first window index
    localparam logic [5:0] IDX_WINDOW_BASE = 6'h10;
    localparam logic [2:0] WIN_START_X_LOW = 3'h0;
    localparam logic [2:0] WIN_START_X_HIGH = 3'h1;
    localparam logic [2:0] WIN_STOP_X_LOW = 3'h2;
    localparam logic [2:0] WIN_STOP_X_HIGH = 3'h3;
    localparam logic [2:0] WIN_START_Y_LOW = 3'h4;
    localparam logic [2:0] WIN_START_Y_HIGH = 3'h5;
    localparam logic [2:0] WIN_STOP_Y_LOW = 3'h6;
    localparam logic [2:0] WIN_STOP_Y_HIGH = 3'h7;

    // field layouts
    localparam int ORIGIN_WIDTH = 6;
    localparam int COORD_WIDTH = 12;
    localparam int HIGH_FIELD_WIDTH = 4;
    localparam logic [7:0] ORIGIN_FIELD_MASK = 8'h3F;
    localparam logic [7:0] HIGH_FIELD_MASK = 8'h0F;

    // reset values
    localparam logic [5:0] SPRITE_ORIGIN_RESET = 6'h1F;

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // one corner of the window rectangle
    typedef struct packed {
        logic [11:0] x;
        logic [11:0] y;
    } coord_pair_type;

    // sprite origin offsets
    typedef struct packed {
        logic [5:0] x;
        logic [5:0] y;
    } origin_pair_type;

endpackage : coord_regs_pkg

/* File: logic/cursor_window_coord_regs.sv */
// module: double-buffered sprite origin and window corner registers behind an AXI4-Lite slave
//
// Operation
// - sprite origin holds six bits, 0 to 63; bits 7 and 6 read zero
// - both sprite origins reset to 31, centring the crosshair in the sprite
// - sprite corner is crosshair position minus programmed origin
// - new sprite origin applies at retrace after both X and Y written
// - sprite origin registers accept reads and writes at any time
// - window start coordinates are 12 bits: low byte plus high nibble
// - bits 7 to 4 of window start high registers read zero
// - window start and stop registers have no reset value
// - active window start changes at retrace after start Y high written
// - window stop coordinates are 12 bits: low byte plus high nibble
// - bits 7 to 4 of window stop high registers read zero
// - active window stop changes at retrace after stop Y high written
// - window start is upper-left corner, included in the window
// - window stop is lower-right corner, included in the window
// - coordinates 0 to 4095 are offsets from first displayed pixel
// - one start/stop pair serves crosshair window or auxiliary window
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module cursor_window_coord_regs (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // video timing and cursor logic
    input wire logic vretrace_i,
    input wire logic [11:0] cursor_x_i,
    input wire logic [11:0] cursor_y_i,
    input wire logic [11:0] pixel_x_i,
    input wire logic [11:0] pixel_y_i,
    // active coordinates
    output coord_regs_pkg::origin_pair_type sprite_origin_o,
    output coord_regs_pkg::coord_pair_type sprite_corner_o,
    output coord_regs_pkg::coord_pair_type window_start_o,
    output coord_regs_pkg::coord_pair_type window_stop_o,
    output logic in_window_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic [5:0] wr_idx_reg;
    logic [7:0] wr_data_reg;
    logic wr_lane_reg;
    logic wr_fire;
    logic [7:0] rd_value;
    logic rd_mapped;
    logic [5:0] rd_idx;
    logic [5:0] rd_idx_reg;

    logic [5:0] origin_x_reg;
    logic [5:0] origin_y_reg;
    logic [7:0] win_reg [0:7];
    logic wr_origin_x;
    logic wr_origin_y;
    logic wr_win_any;
    logic [2:0] wr_win_sel;

    logic pend_x_reg;
    logic pend_y_reg;
    logic pend_start_reg;
    logic pend_stop_reg;

    logic retrace_s1_reg;
    logic retrace_s2_reg;
    logic retrace_s3_reg;
    logic retrace_start;

    coord_regs_pkg::origin_pair_type origin_act_reg;
    coord_regs_pkg::coord_pair_type start_act_reg;
    coord_regs_pkg::coord_pair_type stop_act_reg;
    coord_regs_pkg::coord_pair_type start_shadow;
    coord_regs_pkg::coord_pair_type stop_shadow;
    coord_regs_pkg::coord_pair_type corner_reg;
    logic in_window_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel

    // both address and data captured; the write happens with the response
    assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;

    // address and data may arrive in either order; each ready drops once taken
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= coord_regs_pkg::RESP_OKAY;
            wr_idx_reg <= 6'h00;
            wr_data_reg <= 8'h00;
            wr_lane_reg <= 1'b0;
        end
        else
        begin
            if (awready_reg && s_axi_awvalid_i)
            begin
                awready_reg <= 1'b0;
                wr_idx_reg <= s_axi_awaddr_i[7:2];
            end
            if (wready_reg && s_axi_wvalid_i)
            begin
                wready_reg <= 1'b0;
                wr_data_reg <= s_axi_wdata_i[7:0];
                wr_lane_reg <= s_axi_wstrb_i[0];
            end
            if (wr_fire)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg <= (wr_origin_x || wr_origin_y || wr_win_any) ?
                    coord_regs_pkg::RESP_OKAY : coord_regs_pkg::RESP_SLVERR;
            end
            else if (bvalid_reg && s_axi_bready_i)
            begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // decode of the captured write index
    assign wr_origin_x = (wr_idx_reg == coord_regs_pkg::IDX_SPRITE_ORIGIN_X);
    assign wr_origin_y = (wr_idx_reg == coord_regs_pkg::IDX_SPRITE_ORIGIN_Y);
    assign wr_win_any = (wr_idx_reg[5:3] == coord_regs_pkg::IDX_WINDOW_BASE[5:3]);
    assign wr_win_sel = wr_idx_reg[2:0];

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel

    assign rd_idx = s_axi_araddr_i[7:2];

    // read mux: pending shadow values, unused bits zero
    always_comb
    begin
        rd_value = 8'h00;
        rd_mapped = 1'b1;
        if (rd_idx == coord_regs_pkg::IDX_SPRITE_ORIGIN_X)
            rd_value = {2'b00, origin_x_reg};
        else if (rd_idx == coord_regs_pkg::IDX_SPRITE_ORIGIN_Y)
            rd_value = {2'b00, origin_y_reg};
        else if (rd_idx[5:3] == coord_regs_pkg::IDX_WINDOW_BASE[5:3])
            rd_value = win_reg[rd_idx[2:0]];
        else
            rd_mapped = 1'b0;
    end

    // one read at a time; data latched with the address handshake
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg <= coord_regs_pkg::RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
            rd_idx_reg <= 6'h00;
        end
        else if (arready_reg && s_axi_arvalid_i)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h00_0000, rd_value};
            rresp_reg <= rd_mapped ? coord_regs_pkg::RESP_OKAY : coord_regs_pkg::RESP_SLVERR;
            rd_idx_reg <= rd_idx;
        end
        else if (rvalid_reg && s_axi_rready_i)
        begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // host-visible shadow registers

    // sprite origin: writable at any time regardless of display timing
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            origin_x_reg <= coord_regs_pkg::SPRITE_ORIGIN_RESET;
            origin_y_reg <= coord_regs_pkg::SPRITE_ORIGIN_RESET;
        end
        else if (wr_fire && wr_lane_reg)
        begin
            if (wr_origin_x)
                origin_x_reg <= wr_data_reg[5:0];
            if (wr_origin_y)
                origin_y_reg <= wr_data_reg[5:0];
        end
    end

    // window bytes carry no reset; high bytes keep only their nibble
    generate
        for (genvar i = 0; i < 8; i++)
        begin : g_win
            always_ff @(posedge core_clk_i)
            begin
                if (wr_fire && wr_lane_reg && wr_win_any && wr_win_sel == 3'(i))
                    win_reg[i] <= (i % 2 == 1) ?
                        (wr_data_reg & coord_regs_pkg::HIGH_FIELD_MASK) : wr_data_reg;
            end
        end
    endgenerate

    // twelve-bit corners assembled from low byte and high nibble
    assign start_shadow.x = {win_reg[coord_regs_pkg::WIN_START_X_HIGH][3:0],
        win_reg[coord_regs_pkg::WIN_START_X_LOW]};
    assign start_shadow.y = {win_reg[coord_regs_pkg::WIN_START_Y_HIGH][3:0],
        win_reg[coord_regs_pkg::WIN_START_Y_LOW]};
    assign stop_shadow.x = {win_reg[coord_regs_pkg::WIN_STOP_X_HIGH][3:0],
        win_reg[coord_regs_pkg::WIN_STOP_X_LOW]};
    assign stop_shadow.y = {win_reg[coord_regs_pkg::WIN_STOP_Y_HIGH][3:0],
        win_reg[coord_regs_pkg::WIN_STOP_Y_LOW]};

    ////////////////////////////////////////////////////////////////////////////////
    // vertical retrace detection

    // retrace comes from the video timing, so it is synchronised first
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            retrace_s1_reg <= 1'b0;
            retrace_s2_reg <= 1'b0;
            retrace_s3_reg <= 1'b0;
        end
        else
        begin
            retrace_s1_reg <= vretrace_i;
            retrace_s2_reg <= retrace_s1_reg;
            retrace_s3_reg <= retrace_s2_reg;
        end
    end

    // only the leading edge transfers, so a long retrace loads just once
    assign retrace_start = retrace_s2_reg && !retrace_s3_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // pending flags; a write landing on the transfer edge wins over the clear

    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            pend_x_reg <= 1'b0;
            pend_y_reg <= 1'b0;
            pend_start_reg <= 1'b0;
            pend_stop_reg <= 1'b0;
        end
        else
        begin
            if (wr_fire && wr_lane_reg && wr_origin_x)
                pend_x_reg <= 1'b1;
            else if (retrace_start && pend_x_reg && pend_y_reg)
                pend_x_reg <= 1'b0;
            if (wr_fire && wr_lane_reg && wr_origin_y)
                pend_y_reg <= 1'b1;
            else if (retrace_start && pend_x_reg && pend_y_reg)
                pend_y_reg <= 1'b0;
            if (wr_fire && wr_lane_reg && wr_win_any &&
                wr_win_sel == coord_regs_pkg::WIN_START_Y_HIGH)
                pend_start_reg <= 1'b1;
            else if (retrace_start)
                pend_start_reg <= 1'b0;
            if (wr_fire && wr_lane_reg && wr_win_any &&
                wr_win_sel == coord_regs_pkg::WIN_STOP_Y_HIGH)
                pend_stop_reg <= 1'b1;
            else if (retrace_start)
                pend_stop_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // active copies loaded at the start of retrace

    // sprite origin needs both halves written before it moves
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            origin_act_reg.x <= coord_regs_pkg::SPRITE_ORIGIN_RESET;
            origin_act_reg.y <= coord_regs_pkg::SPRITE_ORIGIN_RESET;
        end
        else if (retrace_start && pend_x_reg && pend_y_reg)
        begin
            origin_act_reg.x <= origin_x_reg;
            origin_act_reg.y <= origin_y_reg;
        end
    end

    // window corners are undefined until loaded, hence no reset
    always_ff @(posedge core_clk_i)
    begin
        if (retrace_start && pend_start_reg)
            start_act_reg <= start_shadow;
        if (retrace_start && pend_stop_reg)
            stop_act_reg <= stop_shadow;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sprite placement and window test

    // sprite upper-left corner, wrapping within the 12-bit screen space
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
            corner_reg <= '0;
        else
        begin
            corner_reg.x <= cursor_x_i - {6'h00, origin_act_reg.x};
            corner_reg.y <= cursor_y_i - {6'h00, origin_act_reg.y};
        end
    end

    // one rectangle shared by crosshair and auxiliary windows, both corners inclusive
    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
            in_window_reg <= 1'b0;
        else
            in_window_reg <= (pixel_x_i >= start_act_reg.x) && (pixel_y_i >= start_act_reg.y)
                && (pixel_x_i <= stop_act_reg.x) && (pixel_y_i <= stop_act_reg.y);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o = wready_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rresp_o = rresp_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign sprite_origin_o = origin_act_reg;
    assign sprite_corner_o = corner_reg;
    assign window_start_o = start_act_reg;
    assign window_stop_o = stop_act_reg;
    assign in_window_o = in_window_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    AST_ORIGIN_RESET: assert property (@(posedge core_clk_i)
        !reset_n_i |=> origin_act_reg.x == 6'h1F && origin_act_reg.y == 6'h1F)
        else $error("sprite origin not 31 after reset");

    AST_ORIGIN_READ_TOP_ZERO: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        rvalid_reg && rd_idx_reg[5:1] == 5'h02 |-> rdata_reg[31:6] == 26'h0)
        else $error("sprite origin read shows bits above five");

    AST_HIGH_READ_TOP_ZERO: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        rvalid_reg && rd_idx_reg[5:3] == 3'h2 && rd_idx_reg[0] |-> rdata_reg[31:4] == 28'h0)
        else $error("window high register read shows upper bits");

    AST_ORIGIN_NEEDS_BOTH: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        !(retrace_start && pend_x_reg && pend_y_reg) |=> $stable(origin_act_reg))
        else $error("sprite origin moved without retrace and both writes");

    AST_ORIGIN_LOAD: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        retrace_start && pend_x_reg && pend_y_reg |=>
        origin_act_reg.x == $past(origin_x_reg) && origin_act_reg.y == $past(origin_y_reg) &&
        (!pend_x_reg || $past(wr_fire && wr_lane_reg && wr_origin_x)))
        else $error("sprite origin not loaded at retrace");

    AST_START_LOAD: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        retrace_start && pend_start_reg |=> start_act_reg == $past(start_shadow))
        else $error("window start not loaded at retrace");

    AST_STOP_HOLD: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        !(retrace_start && pend_stop_reg) ##1 reset_n_i |-> $stable(stop_act_reg))
        else $error("window stop changed outside retrace");

    AST_INSIDE_TEST: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (pixel_x_i == start_act_reg.x && pixel_y_i == start_act_reg.y ||
        pixel_x_i == stop_act_reg.x && pixel_y_i == stop_act_reg.y) &&
        start_act_reg.x <= stop_act_reg.x && start_act_reg.y <= stop_act_reg.y
        |=> in_window_reg)
        else $error("corner pixel not inside window");

    AST_CORNER_CALC: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        reset_n_i |=> corner_reg.x == 12'($past(cursor_x_i) - {6'h00, $past(origin_act_reg.x)}))
        else $error("sprite corner not crosshair minus origin");

    AST_WRITE_RESPONSE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        wr_fire |=> bvalid_reg && ($stable(origin_act_reg) || $past(retrace_start)))
        else $error("write not answered in one cycle");

    COV_ORIGIN_UPDATE: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
        retrace_start && pend_x_reg && pend_y_reg);
    COV_WRITE_ON_RETRACE: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
        wr_fire && wr_origin_x && retrace_start);
    COV_START_UPDATE: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
        retrace_start && pend_start_reg);
    COV_UNMAPPED_READ: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
        rvalid_reg && rresp_reg == coord_regs_pkg::RESP_SLVERR);

endmodule : cursor_window_coord_regs

/* File: test/host_bus_model.sv */
// file: axi4-lite host model issuing single register reads and writes
`timescale 1ns/1ps
module host_bus_model (
    input wire logic core_clk_i,
    output logic [7:0] awaddr_o,
    output logic awvalid_o,
    input wire logic awready_i,
    output logic [31:0] wdata_o,
    output logic [3:0] wstrb_o,
    output logic wvalid_o,
    input wire logic wready_i,
    input wire logic [1:0] bresp_i,
    input wire logic bvalid_i,
    output logic bready_o,
    output logic [7:0] araddr_o,
    output logic arvalid_o,
    input wire logic arready_i,
    input wire logic [31:0] rdata_i,
    input wire logic [1:0] rresp_i,
    input wire logic rvalid_i,
    output logic rready_o,
    output logic hung_o
);
    // byte lanes of the next write; the bench may clear them to test a masked write
    logic [3:0] strb_sel = 4'hF;

    // idle bus from time zero so the slave never sees a stray request
    initial
    begin
        {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o, hung_o} = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // address and data offered together, each dropped when taken
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data,
                             output logic [1:0] resp);
        int n;
        resp = 2'h3;
        @(posedge core_clk_i);
        awaddr_o <= addr;
        wdata_o <= {24'h000000, data};
        wstrb_o <= strb_sel;
        awvalid_o <= 1'b1;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1;
        for (n = 0; n < 64; n++)
        begin
            @(posedge core_clk_i);
            if (awvalid_o && awready_i) awvalid_o <= 1'b0;
            if (wvalid_o && wready_i) wvalid_o <= 1'b0;
            if (bvalid_i === 1'b1) break;
        end
        if (n == 64) hung_o <= 1'b1; else resp = bresp_i;
        bready_o <= 1'b0;
    endtask : write_reg

    // rready held from the request until rvalid is seen
    task automatic read_reg(input logic [7:0] addr, output logic [31:0] data,
                            output logic [1:0] resp);
        int n;
        resp = 2'h3;
        data = 32'h00000000;
        @(posedge core_clk_i);
        araddr_o <= addr;
        arvalid_o <= 1'b1;
        rready_o <= 1'b1;
        for (n = 0; n < 64; n++)
        begin
            @(posedge core_clk_i);
            if (arvalid_o && arready_i) arvalid_o <= 1'b0;
            if (rvalid_i === 1'b1) break;
        end
        if (n == 64) hung_o <= 1'b1;
        else
        begin
            data = rdata_i;
            resp = rresp_i;
        end
        rready_o <= 1'b0;
    endtask : read_reg
endmodule : host_bus_model

/* File: test/tb_cursor_window_coord_regs.sv */
// file: self-checking bench of the sprite origin and window corner bank
`timescale 1ns/1ps
module tb_cursor_window_coord_regs;
    logic core_clk_i, reset_n_i, vretrace_i, in_window;
    logic [11:0] cursor_x_i, cursor_y_i, pixel_x_i, pixel_y_i;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, hung;
    logic [1:0] bresp, rresp;
    coord_regs_pkg::origin_pair_type sprite_origin;
    coord_regs_pkg::coord_pair_type sprite_corner, window_start, window_stop;
    int n_errors = 0;
    int n_compared = 0;
    logic [7:0] wv [8] = '{8'h23, 8'hF1, 8'hBC, 8'hFA, 8'h45, 8'hF0, 8'h78, 8'hF6};
    logic [24:0] pt [6] = '{{12'h100, 12'h145, 1'b1}, {12'h0FF, 12'h145, 1'b0},
        {12'h100, 12'h144, 1'b0}, {12'hABC, 12'h678, 1'b1},
        {12'hABD, 12'h678, 1'b0}, {12'hABC, 12'h679, 1'b0}};

    cursor_window_coord_regs u_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .vretrace_i(vretrace_i),
        .cursor_x_i(cursor_x_i), .cursor_y_i(cursor_y_i), .pixel_x_i(pixel_x_i),
        .pixel_y_i(pixel_y_i), .sprite_origin_o(sprite_origin),
        .sprite_corner_o(sprite_corner), .window_start_o(window_start),
        .window_stop_o(window_stop), .in_window_o(in_window));

    host_bus_model u_host (.core_clk_i(core_clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
        .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid),
        .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
        .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
        .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready), .hung_o(hung));

    ////////////////////////////////////////////////////////////////////////////////
    // 40 MHz core clock
    initial
    begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // byte address is four times the register index
    task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic [1:0] r;
        u_host.write_reg({idx, 2'b00}, d, r);
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask : wr

    task automatic rd(input logic [5:0] idx, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        u_host.read_reg({idx, 2'b00}, d, r);
        chk("rdata", e, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask : rd

    // retrace held long enough to pass the two-stage synchroniser and edge detect
    task automatic retrace();
        @(posedge core_clk_i);
        vretrace_i <= 1'b1;
        repeat (8) @(posedge core_clk_i);
        vretrace_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
    endtask : retrace

    task automatic finish_test();
        if (hung === 1'b1) n_errors++;
        if (n_errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        reset_n_i = 1'b0;
        vretrace_i = 1'b0;
        cursor_x_i = 12'h010;
        cursor_y_i = 12'h002;
        {pixel_x_i, pixel_y_i} = '0;
        repeat (12) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        @(posedge core_clk_i);
        chk("origin", {20'h0, 12'h7DF}, {20'h0, sprite_origin});
        rd(coord_regs_pkg::IDX_SPRITE_ORIGIN_Y, 32'h1F, coord_regs_pkg::RESP_OKAY);
        wr(coord_regs_pkg::IDX_SPRITE_ORIGIN_X, 8'hFF, coord_regs_pkg::RESP_OKAY);
        rd(coord_regs_pkg::IDX_SPRITE_ORIGIN_X, 32'h3F, coord_regs_pkg::RESP_OKAY);
        retrace();
        chk("origin", {20'h0, 12'h7DF}, {20'h0, sprite_origin});
        wr(coord_regs_pkg::IDX_SPRITE_ORIGIN_Y, 8'h05, coord_regs_pkg::RESP_OKAY);
        retrace();
        chk("origin", {20'h0, 12'hFC5}, {20'h0, sprite_origin});
        chk("corner", {8'h0, 24'hFD1FFD}, {8'h0, sprite_corner});
        // start kept on the visible area so the window shows
        for (int i = 0; i < 8; i++) wr(6'h10 + 6'(i), wv[i], 2'h0);
        for (int i = 0; i < 8; i++) rd(6'h10 + 6'(i), {24'h0, wv[i] & (i[0] ? 8'h0F : 8'hFF)},
            2'h0);
        retrace();
        chk("start", {8'h0, 24'h123045}, {8'h0, window_start});
        chk("stop", {8'h0, 24'hABC678}, {8'h0, window_stop});
        // x bytes alone must stay pending
        wr(coord_regs_pkg::IDX_WINDOW_START_X_LOW, 8'h00, coord_regs_pkg::RESP_OKAY);
        wr(coord_regs_pkg::IDX_WINDOW_STOP_X_LOW, 8'h00, coord_regs_pkg::RESP_OKAY);
        retrace();
        chk("start", {8'h0, 24'h123045}, {8'h0, window_start});
        rd(coord_regs_pkg::IDX_WINDOW_STOP_X_LOW, 32'h0, coord_regs_pkg::RESP_OKAY);
        wr(coord_regs_pkg::IDX_WINDOW_START_Y_HIGH, 8'h01, coord_regs_pkg::RESP_OKAY);
        retrace();
        chk("start", {8'h0, 24'h100145}, {8'h0, window_start});
        chk("stop", {8'h0, 24'hABC678}, {8'h0, window_stop});
        // corners inclusive, one pixel outside excluded
        for (int i = 0; i < 6; i++)
        begin
            @(posedge core_clk_i);
            {pixel_x_i, pixel_y_i} <= pt[i][24:1];
            repeat (3) @(posedge core_clk_i);
            chk("in_window", {31'h0, pt[i][0]}, {31'h0, in_window});
        end
        // lane 0 disabled: the write is answered but leaves the register alone
        u_host.strb_sel = 4'h0;
        wr(coord_regs_pkg::IDX_SPRITE_ORIGIN_X, 8'h11, coord_regs_pkg::RESP_OKAY);
        u_host.strb_sel = 4'hF;
        rd(coord_regs_pkg::IDX_SPRITE_ORIGIN_X, 32'h3F, coord_regs_pkg::RESP_OKAY);
        rd(6'h3F, 32'h0, coord_regs_pkg::RESP_SLVERR);
        wr(6'h3F, 8'h55, coord_regs_pkg::RESP_SLVERR);
        finish_test();
    end
endmodule : tb_cursor_window_coord_regs
